// >>> pkg/local_bus_arbiter_params.svh
`ifndef LOCAL_BUS_ARBITER_PARAMS_SVH
`define LOCAL_BUS_ARBITER_PARAMS_SVH

// Arbitration clock period in ns
`define ARB_CLK_PERIOD_NS   100
// DRAM precharge time after a bus owner lets go, in ns
`define ARB_PRECHARGE_NS    200
// Whole cycles, rounded up; a zero time gives zero cycles
`define ARB_PRECHARGE_CYC   ((`ARB_PRECHARGE_NS + `ARB_CLK_PERIOD_NS - 1) / `ARB_CLK_PERIOD_NS)
// Refresh cycle length in arbitration clocks
`define ARB_REFRESH_CYC     4

`endif

// >>> pkg/local_bus_arbiter_pkg.sv
package local_bus_arbiter_pkg;

   typedef enum logic [2:0] {
      ST_CPU_OWNS,
      ST_REQUEST,
      ST_ACQUIRE,
      ST_REFRESH,
      ST_LAN,
      ST_PRECHARGE,
      ST_RELEASE
   } arb_state_t;

   // Handshake toward the host CPU, held at the active-low pin levels
   typedef struct packed {
      logic request;
      logic acknowledge;
   } cpu_arb_t;

endpackage

// >>> rtl/local_bus_arbiter.sv
`timescale 1ns/100ps
//
// Overview of operation
// - Fixed priority: refresh first, then coprocessor, host CPU only when both idle.
// - Assert CPU bus request, await grant, then hold acknowledge while another master owns.
// - Release: drop request, CPU drops grant, then drop acknowledge.
// - Asynchronous refresh request passes a two-flop synchroniser before use.
// - After refresh, bus goes to the highest priority pending requester.
// - Refresh during CPU ownership: request, acknowledge on grant, refresh, drop request.
// - Refresh arriving during coprocessor ownership waits until coprocessor finishes.
// - In that case the CPU request stays until the deferred refresh completes.
// - Coprocessor request during refresh keeps CPU request until both finish.
// - Refresh indication to memory controller is active throughout a refresh cycle.
// - Coprocessor grant is the inverse of the internal active-low cycle signal.
// - Backoff pin may force the coprocessor off the bus where present.
// - Polarity translated between active-high hold/grant and active-low CPU signals, retimed.
// - Logic runs on the arbitration clock, the inverted host CPU clock.
// - No new owner until the DRAM precharge interval has passed.
//
`include "local_bus_arbiter_params.svh"

module local_bus_arbiter
   import local_bus_arbiter_pkg::*;
#(
   parameter int unsigned REFRESH_CYC   = `ARB_REFRESH_CYC,
   parameter int unsigned PRECHARGE_CYC = `ARB_PRECHARGE_CYC,
   parameter bit          HAS_BACKOFF   = 1'b1
) (
   input  wire logic i_clk,
   input  wire logic i_nrst,
   input  wire logic i_refresh_request,
   input  wire logic i_lan_hold,
   input  wire logic i_cpu_bus_grant_n,
   input  wire logic i_lan_backoff_request,
   output logic      o_cpu_bus_request_n,
   output logic      o_cpu_grant_acknowledge_n,
   output logic      o_lan_bus_grant,
   output logic      o_lan_backoff,
   output logic      o_refresh_cycle
);

   // Counters are eight bits wide and count down to one
   if (REFRESH_CYC < 1 || REFRESH_CYC > 255 || PRECHARGE_CYC < 1 || PRECHARGE_CYC > 255) begin : g_bad_counts
      $error("local_bus_arbiter: counts must lie in 1..255");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Input synchronisers; refresh and grant come from other timing domains

   logic [1:0] refresh_sync_q;
   logic [1:0] grant_sync_q;
   logic [1:0] hold_sync_q;
   logic [1:0] lan_backoff_sync_q;

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         refresh_sync_q <= 2'h0;
         grant_sync_q   <= 2'h0;
         hold_sync_q    <= 2'h0;
         lan_backoff_sync_q    <= 2'h0;
      end else begin
         refresh_sync_q <= {refresh_sync_q[0], i_refresh_request};
         grant_sync_q   <= {grant_sync_q[0], ~i_cpu_bus_grant_n};
         hold_sync_q    <= {hold_sync_q[0], i_lan_hold};
         lan_backoff_sync_q    <= {lan_backoff_sync_q[0], i_lan_backoff_request};
      end
   end

   logic refresh_req;
   logic cpu_granted;
   logic lan_req;
   assign refresh_req = refresh_sync_q[1];
   assign cpu_granted = grant_sync_q[1];
   assign lan_req     = hold_sync_q[1];

   ////////////////////////////////////////////////////////////////////////////
   // Refresh pending flag: set wins over clear

   logic refresh_pend_q;
   logic refresh_seen_q;
   logic refresh_done;

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         refresh_seen_q <= 1'b0;
      end else begin
         refresh_seen_q <= refresh_req;
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         refresh_pend_q <= 1'b0;
      end else if (refresh_req && !refresh_seen_q) begin
         refresh_pend_q <= 1'b1;
      end else if (refresh_done) begin
         refresh_pend_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Arbitration state machine, clocked by the arbitration clock

   arb_state_t state_q;
   logic [7:0] count_q;
   cpu_arb_t   cpu_n_q;
   logic       lan_cycle_active_n_q;
   logic       refresh_cycle_q;
   logic       backoff_q;

   assign refresh_done = (state_q == ST_REFRESH) && (count_q == 8'h01);

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         state_q <= ST_CPU_OWNS;
         count_q <= 8'h00;
      end else begin
         case (state_q)
            ST_CPU_OWNS: begin
               if (refresh_pend_q || lan_req) begin
                  state_q <= ST_REQUEST;
               end
            end
            ST_REQUEST: begin
               if (cpu_granted) begin
                  state_q <= ST_ACQUIRE;
               end
            end
            ST_ACQUIRE: begin
               // Acknowledge is out now; pick owner by priority
               if (refresh_pend_q) begin
                  state_q <= ST_REFRESH;
                  count_q <= REFRESH_CYC[7:0];
               end else if (lan_req) begin
                  state_q <= ST_LAN;
               end else begin
                  state_q <= ST_RELEASE;
               end
            end
            ST_REFRESH: begin
               if (count_q == 8'h01) begin
                  state_q <= ST_PRECHARGE;
                  count_q <= PRECHARGE_CYC[7:0];
               end else begin
                  count_q <= count_q - 8'h01;
               end
            end
            ST_LAN: begin
               // Refresh waits until the coprocessor drops hold
               if (!lan_req) begin
                  state_q <= ST_PRECHARGE;
                  count_q <= PRECHARGE_CYC[7:0];
               end
            end
            ST_PRECHARGE: begin
               if (count_q > 8'h01) begin
                  count_q <= count_q - 8'h01;
               end else if (refresh_pend_q) begin
                  state_q <= ST_REFRESH;
                  count_q <= REFRESH_CYC[7:0];
               end else if (lan_req) begin
                  state_q <= ST_LAN;
               end else begin
                  state_q <= ST_RELEASE;
               end
            end
            ST_RELEASE: begin
               // Acknowledge held until the CPU drops its grant
               if (!cpu_granted) begin
                  state_q <= ST_CPU_OWNS;
               end
            end
            default: begin
               state_q <= ST_CPU_OWNS;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registered outputs; grant, refresh and acknowledge decoded from the next state so they align with it

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         cpu_n_q              <= '1;
         lan_cycle_active_n_q <= 1'b1;
         refresh_cycle_q      <= 1'b0;
         backoff_q            <= 1'b0;
      end else begin
         // Pin levels kept in the flop so the CPU request and acknowledge outputs need no gate after it
         cpu_n_q.request <= !(((state_q != ST_RELEASE) && (state_q != ST_CPU_OWNS))
                              || (state_q == ST_CPU_OWNS && (refresh_pend_q || lan_req)));
         if (state_q == ST_REQUEST && cpu_granted) begin
            cpu_n_q.acknowledge <= 1'b0;
         end else if (state_q == ST_RELEASE && !cpu_granted) begin
            cpu_n_q.acknowledge <= 1'b1;
         end
         lan_cycle_active_n_q <= !((state_q == ST_ACQUIRE && !refresh_pend_q && lan_req)
                                   || (state_q == ST_PRECHARGE && count_q <= 8'h01
                                       && !refresh_pend_q && lan_req)
                                   || (state_q == ST_LAN && lan_req));
         refresh_cycle_q <= (state_q == ST_REFRESH && count_q != 8'h01)
                            || ((state_q == ST_ACQUIRE || (state_q == ST_PRECHARGE && count_q <= 8'h01))
                                && refresh_pend_q);
         // Forced release only while coprocessor owns and a refresh waits or the backoff pin is asserted
         backoff_q <= HAS_BACKOFF && (state_q == ST_LAN) && (refresh_pend_q || lan_backoff_sync_q[1]);
      end
   end

   assign o_cpu_bus_request_n       = cpu_n_q.request;
   assign o_cpu_grant_acknowledge_n = cpu_n_q.acknowledge;
   assign o_lan_bus_grant           = ~lan_cycle_active_n_q;
   assign o_refresh_cycle           = refresh_cycle_q;
   assign o_lan_backoff             = backoff_q;

endmodule

// >>> verification/local_bus_arbiter_asserts.sv
`timescale 1ns/100ps
module arb_checker #(
   parameter int unsigned REFRESH_CYC   = 4,
   parameter int unsigned PRECHARGE_CYC = 2,
   parameter bit          HAS_BACKOFF   = 1'b1
) (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_refresh_request,
   input wire logic i_lan_hold,
   input wire logic i_cpu_bus_grant_n,
   input wire logic i_lan_backoff_request,
   input wire logic o_cpu_bus_request_n,
   input wire logic o_cpu_grant_acknowledge_n,
   input wire logic o_lan_bus_grant,
   input wire logic o_lan_backoff,
   input wire logic o_refresh_cycle
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_nrst);
   // Repetition counts below are plain numbers tied to these defaults
   if (REFRESH_CYC != 4 || PRECHARGE_CYC != 2) begin : g_fixed_counts
      $error("arb_checker: lengths assume 4 refresh and 2 precharge cycles");
   end
   ////////////////////////////////////////////////////////////////////////
   property p_gnt_ack; o_lan_bus_grant |-> !o_cpu_grant_acknowledge_n; endproperty
   a_gnt_ack: assert property (p_gnt_ack) else $error("grant without ack");
   property p_ref_ack; o_refresh_cycle |-> !o_cpu_grant_acknowledge_n; endproperty
   a_ref_ack: assert property (p_ref_ack) else $error("refresh without ack");
   property p_one_owner; !(o_lan_bus_grant && o_refresh_cycle); endproperty
   a_one_owner: assert property (p_one_owner) else $error("two owners");
   // Two sync flops plus the decode edge put the cause three ticks back
   property p_ack_on; $fell(o_cpu_grant_acknowledge_n) |-> !o_cpu_bus_request_n && !$past(i_cpu_bus_grant_n, 3); endproperty
   a_ack_on: assert property (p_ack_on) else $error("ack before grant");
   property p_ack_off; $rose(o_cpu_grant_acknowledge_n) |-> o_cpu_bus_request_n && $past(i_cpu_bus_grant_n, 3); endproperty
   a_ack_off: assert property (p_ack_off) else $error("ack released early");
   property p_req_off; $rose(o_cpu_bus_request_n) |-> !o_lan_bus_grant && !o_refresh_cycle; endproperty
   a_req_off: assert property (p_req_off) else $error("request dropped in use");
   property p_ref_len; $rose(o_refresh_cycle) |-> o_refresh_cycle[*4] ##1 !o_refresh_cycle; endproperty
   a_ref_len: assert property (p_ref_len) else $error("refresh length");
   property p_precharge;
      $fell(o_lan_bus_grant) || $fell(o_refresh_cycle) |-> (!o_lan_bus_grant && !o_refresh_cycle)[*2];
   endproperty
   a_precharge: assert property (p_precharge) else $error("no precharge gap");
   property p_hold_keep; $fell(o_lan_bus_grant) |-> !$past(i_lan_hold, 3); endproperty
   a_hold_keep: assert property (p_hold_keep) else $error("grant lost under hold");
   property p_backoff; o_lan_backoff |-> !o_cpu_grant_acknowledge_n; endproperty
   a_backoff: assert property (p_backoff) else $error("backoff off bus");
   c_refresh: cover property ($rose(o_refresh_cycle));
   c_lan: cover property ($rose(o_lan_bus_grant));
   c_backoff: cover property ($rose(o_lan_backoff));
endmodule
bind local_bus_arbiter arb_checker #(.REFRESH_CYC(REFRESH_CYC), .PRECHARGE_CYC(PRECHARGE_CYC),
   .HAS_BACKOFF(HAS_BACKOFF)) u_arb_checker (.i_clk, .i_nrst, .i_refresh_request, .i_lan_hold,
   .i_cpu_bus_grant_n, .i_lan_backoff_request, .o_cpu_bus_request_n, .o_cpu_grant_acknowledge_n,
   .o_lan_bus_grant, .o_lan_backoff, .o_refresh_cycle);

// >>> verification/cpu_arb_model.sv
`timescale 1ns/100ps
module cpu_arb_model (
   input  wire logic       i_clk,
   input  wire logic       i_nrst,
   input  wire logic       i_bus_request_n,
   input  wire logic [3:0] i_delay,
   output logic            o_bus_grant_n
);
   logic [3:0] wait_q;
   // Grant follows request on the (i_delay + 1)th edge after it changes, so slow hosts can be modelled
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         wait_q        <= 4'h0;
         o_bus_grant_n <= 1'b1;
      end else if (i_bus_request_n == o_bus_grant_n) begin
         wait_q <= 4'h0;
      end else if (wait_q >= i_delay) begin
         o_bus_grant_n <= i_bus_request_n;
         wait_q        <= 4'h0;
      end else begin
         wait_q <= wait_q + 4'h1;
      end
   end
endmodule

// >>> verification/tb.sv
`timescale 1ns/100ps
`include "local_bus_arbiter_params.svh"
module tb;
   logic       clk = 0, rst_n = 0, refresh_req = 0, lan_hold = 0, backoff_req = 0;
   logic       grant_n, req_n, ack_n, lan_gnt, backoff, refresh_cyc;
   logic [3:0] dly = 4'h1;
   logic [4:0] obs;
   int         fail_count = 0, n_tests = 0;
   localparam int REQ = 0, ACK = 1, GNT = 2, REF = 3;
   assign obs = {backoff, refresh_cyc, lan_gnt, ack_n, req_n};
   always #50 clk = ~clk;
   local_bus_arbiter u_local_bus_arbiter (.i_clk(clk), .i_nrst(rst_n), .i_refresh_request(refresh_req),
      .i_lan_hold(lan_hold), .i_cpu_bus_grant_n(grant_n), .i_lan_backoff_request(backoff_req),
      .o_cpu_bus_request_n(req_n), .o_cpu_grant_acknowledge_n(ack_n), .o_lan_bus_grant(lan_gnt),
      .o_lan_backoff(backoff), .o_refresh_cycle(refresh_cyc));
   cpu_arb_model u_cpu_arb_model (.i_clk(clk), .i_nrst(rst_n), .i_bus_request_n(req_n), .i_delay(dly),
      .o_bus_grant_n(grant_n));
   ////////////////////////////////////////////////////////////////////////
   task chk(input logic s, input logic e);
      n_tests++;
      if (s !== e) begin
         fail_count++;
         $display("[FAIL] %0t bus signal mismatch", $time);
      end
   endtask
   task tk(input int n);
      repeat (n) @(posedge clk);
      #10;
   endtask
   // Bounded wait, then the level itself is the comparison
   task wt(input int k, input logic v);
      for (int i = 0; i < 80 && obs[k] !== v; i++) tk(1);
      chk(obs[k], v);
   endtask
   task report_and_stop;
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   task t_reset;
      chk(req_n, 1'b1);
      chk(ack_n, 1'b1);
      chk(lan_gnt, 1'b0);
      chk(refresh_cyc, 1'b0);
      $display("reset test done");
   endtask
   task t_refresh;
      int n;
      refresh_req = 1;
      tk(1);
      refresh_req = 0;
      wt(REQ, 0);
      chk(refresh_cyc, 1'b0);
      wt(REF, 1);
      chk(ack_n, 1'b0);
      n = 0;
      while (refresh_cyc === 1'b1 && n < 20) begin
         n++;
         tk(1);
      end
      chk(n == `ARB_REFRESH_CYC, 1'b1);
      wt(REQ, 1);
      wt(ACK, 1);
      chk(grant_n, 1'b1);
      $display("refresh test done");
   endtask
   task t_lan_then_refresh;
      lan_hold = 1;
      wt(GNT, 1);
      refresh_req = 1;
      tk(1);
      refresh_req = 0;
      tk(6);
      chk(refresh_cyc, 1'b0);
      chk(lan_gnt, 1'b1);
      chk(backoff, 1'b1);
      lan_hold = 0;
      wt(REF, 1);
      chk(req_n, 1'b0);
      wt(REQ, 1);
      wt(ACK, 1);
      $display("deferred refresh test done");
   endtask
   task t_refresh_then_lan;
      dly = 4'h8;
      refresh_req = 1;
      lan_hold = 1;
      tk(1);
      refresh_req = 0;
      wt(REF, 1);
      chk(lan_gnt, 1'b0);
      wt(GNT, 1);
      chk(req_n, 1'b0);
      backoff_req = 1;
      tk(4);
      chk(backoff, 1'b1);
      backoff_req = 0;
      lan_hold = 0;
      wt(REQ, 1);
      wt(ACK, 1);
      $display("slow host priority test done");
   endtask
   initial begin
      repeat (5) @(posedge clk);
      #10 rst_n = 1;
      t_reset;
      t_refresh;
      t_lan_then_refresh;
      t_refresh_then_lan;
      report_and_stop;
   end
   initial begin
      #200000;
      fail_count++;
      report_and_stop;
   end
endmodule
